// file: core/mrp_slave.sv
`timescale 1ns/1ns
`include "mrp_cfg.svh"
// RTU slave frame handler for the position controller
module mrp_slave import mrp_pkg::*; #(
  parameter logic [31:0] MAX_COUNT = 32'hFFFFFFFF,
  parameter int REPLY_LIMIT_CYC = `MRP_REPLY_TIME_NS / `MRP_CLK_PERIOD_NS
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_rx_valid,
  input wire mrp_byte_t i_rx_data,
  input wire logic i_rx_gap,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output mrp_byte_t o_tx_data,
  input wire logic i_link_ok,
  input wire logic [31:0] i_raw_position,
  input wire logic [31:0] i_angle,
  input wire logic [31:0] i_last_position,
  input wire logic [15:0] i_temp,
  input wire logic [7:0] i_boot_addr,
  input wire logic [15:0] i_boot_mode,
  input wire logic [15:0] i_boot_baud,
  input wire logic [31:0] i_boot_offset,
  output logic [15:0] o_link_baud_code,
  output logic [15:0] o_mode,
  output logic o_save_pulse,
  output logic [7:0] o_nv_addr,
  output logic [15:0] o_nv_mode,
  output logic [15:0] o_nv_baud,
  output logic [31:0] o_nv_offset
);
  mrp_state_t state_reg, state_next; // Frame phase
  mrp_byte_t rx_buf_reg [0:12]; // Request bytes, kept for the echo
  mrp_byte_t rx_buf_next [0:12];
  logic [3:0] rx_cnt_reg, rx_cnt_next; // Bytes seen, saturates at overflow
  logic [3:0] tx_idx_reg, tx_idx_next; // Next reply byte to load
  logic [3:0] len_reg, len_next; // Reply length before CRC
  logic [7:0] exc_reg, exc_next; // Exception code, zero for normal reply
  logic tx_valid_reg, tx_valid_next;
  mrp_byte_t tx_data_reg, tx_data_next;
  logic boot_done_reg, boot_done_next; // Boot values taken
  logic badval_reg, badval_next; // Wrong value flag
  logic save_reg, save_next;
  logic [15:0] snap_stat_reg, snap_stat_next; // Snapshots so words never tear
  logic [31:0] snap_pos_reg, snap_pos_next;
  logic [31:0] snap_ang_reg, snap_ang_next;
  logic [31:0] newpos_reg, newpos_next; // Working, volatile values
  logic [31:0] offset_reg, offset_next;
  logic [7:0] addr_reg, addr_next;
  logic [15:0] mode_reg, mode_next;
  logic [15:0] baud_reg, baud_next;
  logic [15:0] link_baud_reg, link_baud_next;
  logic [7:0] nv_addr_reg, nv_addr_next; // Committed copies
  logic [15:0] nv_mode_reg, nv_mode_next;
  logic [15:0] nv_baud_reg, nv_baud_next;
  logic [31:0] nv_offset_reg, nv_offset_next;

  logic [15:0] rx_crc, tx_crc;
  logic rx_take, tx_load, tx_feed;
  logic [7:0] fc;
  logic [15:0] start, qty, vcnt, len16, status_word, rd_addr, rd_word;
  logic [31:0] wdata;
  logic hit, frame_ok, writable, range_ok;
  logic [3:0] idx_off;
  mrp_byte_t tx_byte;

  // Request fields; 32-bit write data has its high word first
  assign fc = rx_buf_reg[1];
  assign start = {rx_buf_reg[2], rx_buf_reg[3]};
  assign qty = {rx_buf_reg[4], rx_buf_reg[5]};
  assign len16 = {12'h000, rx_cnt_reg};
  assign wdata = (qty == `MRP_QTY_DOUBLE) ?
    {rx_buf_reg[7], rx_buf_reg[8], rx_buf_reg[9], rx_buf_reg[10]} :
    {16'h0000, rx_buf_reg[7], rx_buf_reg[8]};
  // Own address or the general call
  assign hit = (rx_buf_reg[0] == addr_reg) || (rx_buf_reg[0] == `MRP_GENERAL_ADDR);
  // Bad CRC, wrong address or broken length drops silently
  assign frame_ok = hit && (rx_crc == `MRP_CRC_OK) && (rx_cnt_reg >= `MRP_LEN_MIN) &&
    (rx_cnt_reg <= `MRP_RX_MAX);
  // Lost sensor link outranks a wrong value
  assign status_word = !i_link_ok ? `MRP_ST_NOLINK :
    (badval_reg ? `MRP_ST_BADVAL : `MRP_ST_OK);

  // Register count of the value starting at start
  always_comb begin
    unique case (start)
      `MRP_REG_STATUS, `MRP_REG_ADDR, `MRP_REG_MODE, `MRP_REG_TEMP,
      `MRP_REG_BAUD: vcnt = `MRP_QTY_SINGLE;
      `MRP_REG_POS, `MRP_REG_ANGLE, `MRP_REG_LASTPOS, `MRP_REG_NEWPOS,
      `MRP_REG_OFFSET: vcnt = `MRP_QTY_DOUBLE;
      default: vcnt = `MRP_QTY_NONE;
    endcase
  end

  // Write targets and their ranges; baud codes 0 to 4
  always_comb begin
    writable = 1'b1;
    range_ok = 1'b0;
    unique case (start)
      `MRP_REG_NEWPOS: range_ok = (wdata <= MAX_COUNT);
      `MRP_REG_ADDR: range_ok = (wdata[15:0] >= `MRP_ADDR_MIN) &&
        (wdata[15:0] <= `MRP_ADDR_MAX) && (wdata[15:0] != `MRP_ADDR_BANNED);
      `MRP_REG_MODE: range_ok = (wdata[15:0] <= `MRP_MODE_MAX);
      `MRP_REG_BAUD: range_ok = (wdata[15:0] <= `MRP_BAUD_MAX);
      default: writable = 1'b0;
    endcase
  end

  // Read map; the 32-bit values give high word at lower address
  assign idx_off = tx_idx_reg - `MRP_RD_HDR;
  assign rd_addr = start + {13'h0000, idx_off[3:1]};
  always_comb begin
    unique case (rd_addr)
      `MRP_REG_STATUS: rd_word = snap_stat_reg;
      `MRP_REG_POS: rd_word = snap_pos_reg[31:16];
      `MRP_REG_POS + `MRP_WORD_LO: rd_word = snap_pos_reg[15:0];
      `MRP_REG_ANGLE: rd_word = snap_ang_reg[31:16];
      `MRP_REG_ANGLE + `MRP_WORD_LO: rd_word = snap_ang_reg[15:0];
      `MRP_REG_LASTPOS: rd_word = i_last_position[31:16];
      `MRP_REG_LASTPOS + `MRP_WORD_LO: rd_word = i_last_position[15:0];
      `MRP_REG_NEWPOS: rd_word = newpos_reg[31:16];
      `MRP_REG_NEWPOS + `MRP_WORD_LO: rd_word = newpos_reg[15:0];
      `MRP_REG_OFFSET: rd_word = offset_reg[31:16];
      `MRP_REG_OFFSET + `MRP_WORD_LO: rd_word = offset_reg[15:0];
      `MRP_REG_ADDR: rd_word = {8'h00, addr_reg};
      `MRP_REG_MODE: rd_word = mode_reg;
      `MRP_REG_TEMP: rd_word = i_temp;
      `MRP_REG_BAUD: rd_word = baud_reg;
      default: rd_word = `MRP_ST_OK;
    endcase
  end

  // Reply byte mux: header, data or echo, then CRC low then high
  always_comb begin
    tx_byte = rx_buf_reg[0];
    if (tx_idx_reg == len_reg) begin
      tx_byte = tx_crc[7:0];
    end else if (tx_idx_reg > len_reg) begin
      tx_byte = tx_crc[15:8];
    end else if (tx_idx_reg == 4'h1) begin
      tx_byte = (exc_reg != `MRP_EXC_NONE) ? (fc | `MRP_FC_EXC_BIT) : fc;
    end else if (exc_reg != `MRP_EXC_NONE) begin
      tx_byte = exc_reg;
    end else if (fc == `MRP_FC_READ) begin
      if (tx_idx_reg == 4'h2) begin
        tx_byte = {qty[6:0], 1'b0};
      end else begin
        tx_byte = idx_off[0] ? rd_word[7:0] : rd_word[15:8];
      end
    end else if (tx_idx_reg != 4'h0) begin
      tx_byte = rx_buf_reg[tx_idx_reg];
    end
  end

  assign rx_take = (state_reg == MRP_IDLE) && boot_done_reg && i_rx_valid;
  assign tx_load = (state_reg == MRP_REPLY) && (!tx_valid_reg || i_tx_ready);
  assign tx_feed = tx_load && (tx_idx_reg < len_reg);

  // Next state of the whole handler
  always_comb begin
    state_next = state_reg;
    rx_buf_next = rx_buf_reg;
    rx_cnt_next = rx_cnt_reg;
    tx_idx_next = tx_idx_reg;
    len_next = len_reg;
    exc_next = exc_reg;
    tx_valid_next = tx_valid_reg;
    tx_data_next = tx_data_reg;
    boot_done_next = boot_done_reg;
    badval_next = badval_reg;
    save_next = 1'b0;
    snap_stat_next = snap_stat_reg;
    snap_pos_next = snap_pos_reg;
    snap_ang_next = snap_ang_reg;
    newpos_next = newpos_reg;
    offset_next = offset_reg;
    addr_next = addr_reg;
    mode_next = mode_reg;
    baud_next = baud_reg;
    link_baud_next = link_baud_reg;
    nv_addr_next = nv_addr_reg;
    nv_mode_next = nv_mode_reg;
    nv_baud_next = nv_baud_reg;
    nv_offset_next = nv_offset_reg;
    if (!boot_done_reg) begin
      // Stored values arrive once; the link rate is fixed from here on
      boot_done_next = 1'b1;
      addr_next = i_boot_addr;
      mode_next = i_boot_mode;
      offset_next = i_boot_offset;
      baud_next = (i_boot_baud <= `MRP_BAUD_MAX) ? i_boot_baud : `MRP_BAUD_DEFAULT;
      link_baud_next = (i_boot_baud <= `MRP_BAUD_MAX) ? i_boot_baud : `MRP_BAUD_DEFAULT;
      nv_addr_next = i_boot_addr;
      nv_mode_next = i_boot_mode;
      nv_baud_next = i_boot_baud;
      nv_offset_next = i_boot_offset;
    end
    unique case (state_reg)
      MRP_IDLE: begin
        if (rx_take) begin
          if (rx_cnt_reg < `MRP_RX_MAX) begin
            rx_buf_next[rx_cnt_reg] = i_rx_data;
          end
          if (rx_cnt_reg != `MRP_RX_OVF) begin
            rx_cnt_next = rx_cnt_reg + 4'h1;
          end
        end else if (i_rx_gap && boot_done_reg && (rx_cnt_reg != 4'h0)) begin
          state_next = MRP_CHECK;
        end
      end
      MRP_CHECK: begin
        // Live values frozen for this reply
        snap_stat_next = status_word;
        snap_pos_next = i_raw_position + offset_reg;
        snap_ang_next = i_angle;
        rx_cnt_next = 4'h0;
        tx_idx_next = 4'h0;
        exc_next = `MRP_EXC_NONE;
        len_next = `MRP_ECHO_LEN;
        state_next = frame_ok ? MRP_REPLY : MRP_IDLE;
        if (!frame_ok) begin
          // Dropped without reply
        end else if (fc == `MRP_FC_READ) begin
          // Reads: first five live registers, or one whole value
          if (rx_cnt_reg != `MRP_LEN_FIXED) begin
            exc_next = `MRP_EXC_VALUE;
          end else if (((start == `MRP_REG_STATUS) && (qty != `MRP_QTY_NONE) &&
                        (qty <= `MRP_LIVE_REGS)) ||
                       ((vcnt != `MRP_QTY_NONE) && (qty == vcnt))) begin
            len_next = `MRP_RD_HDR + {qty[2:0], 1'b0};
          end else begin
            exc_next = `MRP_EXC_ADDR;
          end
        end else if (fc == `MRP_FC_WRITE) begin
          // Whole-value writes, quantity one or two
          if ((len16 != `MRP_WR_OVERHEAD + (qty << 1)) ||
              (rx_buf_reg[6] != {qty[6:0], 1'b0})) begin
            exc_next = `MRP_EXC_VALUE;
          end else if (!writable || (qty != vcnt)) begin
            exc_next = `MRP_EXC_ADDR;
          end else if (!range_ok) begin
            badval_next = 1'b1;
          end else begin
            badval_next = 1'b0;
            unique case (start)
              `MRP_REG_NEWPOS: begin
                newpos_next = wdata;
                offset_next = wdata - i_raw_position;
              end
              `MRP_REG_ADDR: addr_next = wdata[7:0];
              `MRP_REG_MODE: mode_next = wdata[15:0];
              default: baud_next = wdata[15:0];
            endcase
          end
        end else if (fc == `MRP_FC_COIL) begin
          if (rx_cnt_reg != `MRP_LEN_FIXED) begin
            exc_next = `MRP_EXC_VALUE;
          end else if (start != `MRP_COIL_SAVE) begin
            exc_next = `MRP_EXC_ADDR;
          end else if (qty == `MRP_COIL_ON) begin
            // Commit working values
            save_next = 1'b1;
            nv_addr_next = addr_reg;
            nv_mode_next = mode_reg;
            nv_baud_next = baud_reg;
            nv_offset_next = offset_reg;
          end else if (qty != `MRP_COIL_OFF) begin
            exc_next = `MRP_EXC_VALUE;
          end
        end else begin
          exc_next = `MRP_EXC_FUNC;
        end
        if (frame_ok && (exc_next != `MRP_EXC_NONE)) begin
          len_next = `MRP_EXC_LEN;
        end
      end
      MRP_REPLY: begin
        // First byte loads the cycle after the check, far inside the limit
        if (tx_load) begin
          // Body bytes, then CRC low and CRC high; a frame is useless without both
          if (tx_idx_reg <= len_reg + 4'h1) begin
            tx_valid_next = 1'b1;
            tx_data_next = tx_byte;
            tx_idx_next = tx_idx_reg + 4'h1;
          end else begin
            tx_valid_next = 1'b0;
            state_next = MRP_IDLE;
          end
        end
      end
    endcase
  end

  // Registers; working values come from the boot inputs after release
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= MRP_IDLE;
      for (int i = 0; i <= 12; i++) begin
        rx_buf_reg[i] <= 8'h00;
      end
      rx_cnt_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      len_reg <= 4'h0;
      exc_reg <= `MRP_EXC_NONE;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      boot_done_reg <= 1'b0;
      badval_reg <= 1'b0;
      save_reg <= 1'b0;
      snap_stat_reg <= `MRP_ST_OK;
      snap_pos_reg <= 32'h00000000;
      snap_ang_reg <= 32'h00000000;
      newpos_reg <= 32'h00000000;
      offset_reg <= 32'h00000000;
      addr_reg <= 8'h00;
      mode_reg <= 16'h0000;
      baud_reg <= `MRP_BAUD_DEFAULT;
      link_baud_reg <= `MRP_BAUD_DEFAULT;
      nv_addr_reg <= 8'h00;
      nv_mode_reg <= 16'h0000;
      nv_baud_reg <= `MRP_BAUD_DEFAULT;
      nv_offset_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      rx_buf_reg <= rx_buf_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_idx_reg <= tx_idx_next;
      len_reg <= len_next;
      exc_reg <= exc_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
      boot_done_reg <= boot_done_next;
      badval_reg <= badval_next;
      save_reg <= save_next;
      snap_stat_reg <= snap_stat_next;
      snap_pos_reg <= snap_pos_next;
      snap_ang_reg <= snap_ang_next;
      newpos_reg <= newpos_next;
      offset_reg <= offset_next;
      addr_reg <= addr_next;
      mode_reg <= mode_next;
      baud_reg <= baud_next;
      link_baud_reg <= link_baud_next;
      nv_addr_reg <= nv_addr_next;
      nv_mode_reg <= nv_mode_next;
      nv_baud_reg <= nv_baud_next;
      nv_offset_reg <= nv_offset_next;
    end
  end

  // Request and reply checksums
  mrp_crc16 u_rx_crc (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_clear(state_reg == MRP_CHECK), .i_valid(rx_take), .i_data(i_rx_data), .o_crc(rx_crc));
  mrp_crc16 u_tx_crc (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_clear(state_reg == MRP_CHECK), .i_valid(tx_feed), .i_data(tx_byte), .o_crc(tx_crc));

  assign o_tx_valid = tx_valid_reg;
  assign o_tx_data = tx_data_reg;
  assign o_link_baud_code = link_baud_reg;
  assign o_mode = mode_reg;
  assign o_save_pulse = save_reg;
  assign o_nv_addr = nv_addr_reg;
  assign o_nv_mode = nv_mode_reg;
  assign o_nv_baud = nv_baud_reg;
  assign o_nv_offset = nv_offset_reg;

  // Helper: cycles from check to first reply byte
  int wait_cnt;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_cnt <= 0;
    end else begin
      wait_cnt <= (state_reg == MRP_IDLE || tx_valid_reg) ? 0 : wait_cnt + 1;
    end
  end

  sequence s_save_req;
    state_reg == MRP_CHECK && frame_ok && fc == `MRP_FC_COIL &&
      rx_cnt_reg == `MRP_LEN_FIXED && start == `MRP_COIL_SAVE && qty == `MRP_COIL_ON;
  endsequence
  sequence s_save_done;
    o_save_pulse && o_nv_addr == $past(addr_reg) ##1 !o_save_pulse;
  endsequence
  property p_save;
    @(posedge i_core_clk) disable iff (!i_rst_b) s_save_req |=> s_save_done;
  endproperty
  a_save: assert property (p_save) else $error("save did not commit");
  property p_nv_hold;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      boot_done_reg && !save_next |=> $stable(o_nv_addr) && $stable(o_nv_baud);
  endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("stored copy moved");
  property p_general;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_reg == MRP_CHECK && rx_buf_reg[0] == `MRP_GENERAL_ADDR && rx_crc == `MRP_CRC_OK
      && rx_cnt_reg >= `MRP_LEN_MIN && rx_cnt_reg <= `MRP_RX_MAX |=> ##1 o_tx_valid;
  endproperty
  a_general: assert property (p_general) else $error("general call unanswered");
  property p_ignore;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_reg == MRP_CHECK && !frame_ok |=> (state_reg == MRP_IDLE && !o_tx_valid)[*2];
  endproperty
  a_ignore: assert property (p_ignore) else $error("bad frame answered");
  property p_nolink;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_reg == MRP_CHECK && !i_link_ok |=> snap_stat_reg == `MRP_ST_NOLINK;
  endproperty
  a_nolink: assert property (p_nolink) else $error("no 770 on lost link");
  property p_badval;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_reg == MRP_CHECK && frame_ok && fc == `MRP_FC_WRITE && exc_next == `MRP_EXC_NONE
      |=> badval_reg == !$past(range_ok) && (i_link_ok -> status_word ==
      (badval_reg ? `MRP_ST_BADVAL : `MRP_ST_OK));
  endproperty
  a_badval: assert property (p_badval) else $error("wrong value flag wrong");
  property p_baud;
    @(posedge i_core_clk) disable iff (!i_rst_b) boot_done_reg |=> $stable(o_link_baud_code);
  endproperty
  a_baud: assert property (p_baud) else $error("link rate changed");
  property p_reply_time;
    @(posedge i_core_clk) disable iff (!i_rst_b) wait_cnt < REPLY_LIMIT_CYC && wait_cnt < 3;
  endproperty
  a_reply_time: assert property (p_reply_time) else $error("reply late");
  property p_read_len;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      state_reg == MRP_CHECK && frame_ok && fc == `MRP_FC_READ && exc_next == `MRP_EXC_NONE
      |=> len_reg == `MRP_RD_HDR + {$past(qty[2:0]), 1'b0};
  endproperty
  a_read_len: assert property (p_read_len) else $error("read length wrong");
endmodule

// file: core/mrp_cfg.svh
// What this block does
// - Link defaults to 57000 class rate, 8N1
// - Always answer general call address 235
// - Register 0 status; first five registers live
// - Position is 32 bits over two registers
// - Lost sensor link reports status 770
// - Bad write value sets 1029; valid clears
// - Values are one or two 16-bit registers
// - Reads served by function code 3
// - Writes taken by function code hex 10
// - Coil 0x02 ON saves values to storage
// - Written values volatile until save command
// - Reply begins within 1 ms of request
// - New baud code waits for next power-up
// - Baud codes 0 to 4 select rates
`ifndef MRP_CFG_SVH
`define MRP_CFG_SVH
`define MRP_GENERAL_ADDR 8'hEB
`define MRP_FC_READ 8'h03
`define MRP_FC_COIL 8'h05
`define MRP_FC_WRITE 8'h10
`define MRP_FC_EXC_BIT 8'h80
`define MRP_EXC_NONE 8'h00
`define MRP_EXC_FUNC 8'h01
`define MRP_EXC_ADDR 8'h02
`define MRP_EXC_VALUE 8'h03
`define MRP_COIL_SAVE 16'h0002
`define MRP_COIL_ON 16'hFF00
`define MRP_COIL_OFF 16'h0000
`define MRP_ST_OK 16'h0000
`define MRP_ST_NOLINK 16'h0302
`define MRP_ST_BADVAL 16'h0405
`define MRP_REG_STATUS 16'h0000
`define MRP_REG_POS 16'h0001
`define MRP_REG_ANGLE 16'h0003
`define MRP_REG_LASTPOS 16'h0005
`define MRP_REG_NEWPOS 16'h0100
`define MRP_REG_OFFSET 16'h0102
`define MRP_REG_ADDR 16'h0104
`define MRP_REG_MODE 16'h0105
`define MRP_REG_TEMP 16'h0106
`define MRP_REG_BAUD 16'h0193
`define MRP_WORD_LO 16'h0001
`define MRP_QTY_NONE 16'h0000
`define MRP_QTY_SINGLE 16'h0001
`define MRP_QTY_DOUBLE 16'h0002
`define MRP_LIVE_REGS 16'h0005
`define MRP_ADDR_MIN 16'h0001
`define MRP_ADDR_MAX 16'h00FE
`define MRP_ADDR_BANNED 16'h0004
`define MRP_MODE_MAX 16'h0003
`define MRP_BAUD_MAX 16'h0004
`define MRP_BAUD_DEFAULT 16'h0003
`define MRP_RX_MAX 4'hD
`define MRP_RX_OVF 4'hE
`define MRP_LEN_MIN 4'h4
`define MRP_LEN_FIXED 4'h8
`define MRP_WR_OVERHEAD 16'h0009
`define MRP_RD_HDR 4'h3
`define MRP_ECHO_LEN 4'h6
`define MRP_EXC_LEN 4'h3
`define MRP_CRC_INIT 16'hFFFF
`define MRP_CRC_POLY 16'hA001
`define MRP_CRC_OK 16'h0000
`define MRP_REPLY_TIME_NS 1000000
`define MRP_CLK_PERIOD_NS 10
`endif

// file: core/mrp_pkg.sv
package mrp_pkg;
  // Frame handler phases
  typedef enum logic [1:0] {MRP_IDLE, MRP_CHECK, MRP_REPLY} mrp_state_t;
  typedef logic [7:0] mrp_byte_t;
endpackage

// file: core/mrp_crc16.sv
`timescale 1ns/1ns
`include "mrp_cfg.svh"
// Byte-serial CRC-16 as used on RTU frames, reflected polynomial
module mrp_crc16 import mrp_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic i_valid,
  input wire mrp_byte_t i_data,
  output logic [15:0] o_crc
);
  logic [15:0] crc_reg; // Running remainder
  logic [15:0] crc_next;

  // One byte per clock, eight shift steps unrolled by the loop
  always_comb begin
    logic [15:0] c;
    c = crc_reg ^ {8'h00, i_data};
    for (int b = 0; b < 8; b++) begin
      c = c[0] ? ((c >> 1) ^ `MRP_CRC_POLY) : (c >> 1);
    end
    crc_next = crc_reg;
    if (i_clear) begin
      crc_next = `MRP_CRC_INIT;
    end else if (i_valid) begin
      crc_next = c;
    end
  end

  // Remainder register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      crc_reg <= `MRP_CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign o_crc = crc_reg;
endmodule

// file: verification/mrp_host_model.sv
`timescale 1ns/1ns
// Host master: frames requests, accepts reply bytes
module mrp_host_model import mrp_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_tx_valid,
  input wire mrp_byte_t i_tx_data,
  output logic o_rx_valid,
  output mrp_byte_t o_rx_data,
  output logic o_rx_gap,
  output logic o_tx_ready
);
  bit slow = 1'b0; // Stall reply bytes on alternate cycles
  int wait_cyc; // Cycles from gap to first reply byte
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_gap = 1'b0;
    o_tx_ready = 1'b1;
  end
  // Reflected CRC-16; a whole good frame leaves zero
  function automatic logic [15:0] crc16(input mrp_byte_t q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction
  // One request at a time; reply ends after 40 silent cycles
  task automatic xfer(input mrp_byte_t req[$], input bit bad, output mrp_byte_t rsp[$]);
    logic [15:0] c;
    int idle;
    c = crc16(req) ^ {15'h0000, bad};
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    rsp = {};
    foreach (req[i]) begin
      o_rx_valid = 1'b1;
      o_rx_data = req[i];
      @(posedge i_core_clk) #1;
    end
    o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data; // Released line shows no stale byte
    o_rx_gap = 1'b1;
    @(posedge i_core_clk) #1;
    o_rx_gap = 1'b0;
    wait_cyc = 0;
    idle = 0;
    while (idle < 40) begin
      @(posedge i_core_clk);
      if (i_tx_valid && o_tx_ready) begin
        rsp.push_back(i_tx_data);
      end
      idle = i_tx_valid ? 0 : idle + 1;
      wait_cyc += (rsp.size() == 0);
      #1;
      o_tx_ready = slow ? ~o_tx_ready : 1'b1;
    end
  endtask
endmodule

// file: verification/mrp_slave_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the slave frame handler
module mrp_slave_tb_top import mrp_pkg::*; ;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic link_ok = 1'b1;
  logic rx_valid, rx_gap, tx_ready, tx_valid, save_pulse;
  mrp_byte_t rx_data, tx_data;
  logic [31:0] raw_pos = 32'h12345678;
  logic [31:0] angle = 32'h00008CA0;
  logic [15:0] baud_code, mode, nv_mode, nv_baud;
  logic [7:0] nv_addr;
  logic [31:0] nv_offset;
  int fails = 0, checks_done = 0, saves = 0;
  mrp_byte_t rsp[$]; // Last reply seen
  always #5 clk = ~clk;
  // Count commit strobes
  always @(posedge clk) saves += save_pulse;
  mrp_slave dut_u (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_gap(rx_gap), .i_tx_ready(tx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_link_ok(link_ok), .i_raw_position(raw_pos), .i_angle(angle),
    .i_last_position(32'hCAFE0001), .i_temp(angle[15:0]), .i_boot_addr(8'h11),
    .i_boot_mode(16'h0000), .i_boot_baud(16'h0003), .i_boot_offset(32'h00000010),
    .o_link_baud_code(baud_code), .o_mode(mode), .o_save_pulse(save_pulse),
    .o_nv_addr(nv_addr), .o_nv_mode(nv_mode), .o_nv_baud(nv_baud), .o_nv_offset(nv_offset)
  );
  mrp_host_model host_u (
    .i_core_clk(clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_rx_gap(rx_gap), .o_tx_ready(tx_ready)
  );
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] w16(input int i);
    return {rsp[i], rsp[i + 1]};
  endfunction
  // Read of qty registers from start: reply size, byte count, CRC and delay checked
  task automatic rd(input mrp_byte_t a, input logic [15:0] start, input mrp_byte_t qty);
    host_u.xfer('{a, 8'h03, start[15:8], start[7:0], 8'h00, qty}, 1'b0, rsp);
    check({rsp.size(), rsp[2]}, {32'(5 + 2 * qty), 8'(qty * 2)});
    check({host_u.crc16(rsp), host_u.wait_cyc <= 3}, {16'h0000, 1'b1});
  endtask
  // Write one or two words in a single request, expect the echo
  task automatic wr(input logic [15:0] start, input logic [31:0] v, input bit dbl);
    mrp_byte_t q[$];
    q = '{8'h11, 8'h10, start[15:8], start[7:0], 8'h00, dbl ? 8'h02 : 8'h01, dbl ? 8'h04 : 8'h02};
    if (dbl) q = {q, v[31:24], v[23:16]};
    q = {q, v[15:8], v[7:0]};
    host_u.xfer(q, 1'b0, rsp);
    check({rsp[1], w16(4), w16(2)}, {8'h10, dbl ? 16'h0002 : 16'h0001, start});
  endtask
  // Live block of five, then last position via the general address
  task automatic s_live;
    rd(8'h11, 16'h0000, 8'h05);
    check({w16(3), w16(5), w16(7), w16(9), w16(11)}, {16'h0000, raw_pos + 32'h10, angle});
    rd(8'hEB, 16'h0005, 8'h02);
    check({w16(3), w16(5), baud_code}, {32'hCAFE0001, 16'h0003});
  endtask
  // Lost sensor with a stalling host, then frames to be ignored
  task automatic s_link_drop;
    link_ok = 1'b0;
    host_u.slow = 1'b1;
    rd(8'hEB, 16'h0000, 8'h01);
    check(w16(3), 16'h0302);
    link_ok = 1'b1;
    host_u.slow = 1'b0;
    host_u.xfer('{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1, rsp);
    check(rsp.size(), 0);
    host_u.xfer('{8'h12, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, rsp);
    check(rsp.size(), 0);
    // Unserved function code gets a short exception reply
    host_u.xfer('{8'h11, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, rsp);
    check({rsp.size(), rsp[1], rsp[2]}, {32'd5, 8'h86, 8'h01});
  endtask
  // Bad value flags status, a good one clears it; position preset
  task automatic s_write;
    wr(16'h0105, 32'h0007, 1'b0);
    rd(8'h11, 16'h0000, 8'h01);
    check(w16(3), 16'h0405);
    wr(16'h0105, 32'h0001, 1'b0);
    rd(8'h11, 16'h0000, 8'h01);
    check({w16(3), mode}, {16'h0000, 16'h0001});
    wr(16'h0100, 32'h00ABCDEF, 1'b1);
    rd(8'h11, 16'h0001, 8'h02);
    check({w16(3), w16(5)}, 32'h00ABCDEF);
  endtask
  // Every rate code stays pending until the save command
  task automatic s_baud_save;
    for (int c = 0; c < 5; c++) begin
      wr(16'h0193, c, 1'b0);
      check({baud_code, nv_baud, 8'(saves)}, {16'h0003, 16'h0003, 8'h00});
      check(nv_offset, 32'h00000010);
    end
    host_u.xfer('{8'h11, 8'h05, 8'h00, 8'h02, 8'hFF, 8'h00}, 1'b0, rsp);
    check({rsp.size(), nv_baud, nv_mode, saves}, {32'd8, 16'h0004, 16'h0001, 32'd1});
    check({nv_addr, nv_offset}, {8'h11, 32'h00ABCDEF - raw_pos});
  endtask
  task automatic end_sim;
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Reset for three cycles, boot edge, then the scenarios
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    s_live;
    s_link_drop;
    s_write;
    s_baud_save;
    end_sim;
  end
  // Watchdog: some 20 frames of under 200 cycles each
  initial begin
    #100000;
    fails++;
    end_sim;
  end
endmodule
